// ### rtl/lin_fault_pkg.sv
// Constants shared by the LIN fault and wake monitor and its timer.
// Assumes a 10 MHz device clock and synchronous pin and analog flags.
package lin_fault_pkg;

    // ----------------------------------------
    // Clock
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 100;

    // ----------------------------------------
    // Supervision times, in their own unit
    // ----------------------------------------
    localparam int TX_DOMINANT_TIMEOUT_US = 20_000;
    localparam int BUS_SHORT_GROUND_TIME_US = 10_000;
    localparam int WAKE_PULSE_MIN_TIME_US = 150;

    // Least times, rounded up to whole cycles
    localparam int TX_DOMINANT_CYCLES =
        (TX_DOMINANT_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUS_SHORT_CYCLES =
        (BUS_SHORT_GROUND_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_PULSE_CYCLES =
        (WAKE_PULSE_MIN_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ----------------------------------------
    // Counter widths and counts
    // ----------------------------------------
    localparam int TIMER_WIDTH = 20;
    localparam int RX_STUCK_WIDTH = 3;
    localparam logic [RX_STUCK_WIDTH-1:0] RX_STUCK_COUNT = 3'h7;
    localparam logic [RX_STUCK_WIDTH-1:0] RX_STUCK_RESET = 3'h0;

    // ----------------------------------------
    // Transceiver mode field
    // ----------------------------------------
    localparam int MODE_MSB = 1;
    localparam logic [1:0] MODE_NORMAL = 2'h3;
    localparam logic [1:0] MODE_LISTEN = 2'h1;
    localparam logic [1:0] MODE_RESET = 2'h0;

endpackage : lin_fault_pkg

// ### rtl/lin_level_timer.sv
// Saturating cycle counter that reports when a level has lasted too long.
// Assumes run is a synchronous level; the count restarts when it drops.
`timescale 1ns/1ps

module lin_level_timer #(
    parameter int LIMIT = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Watched level
    input wire logic run,
    // Limit passed while run held
    output logic expired
);

    logic [lin_fault_pkg::TIMER_WIDTH-1:0] count;
    logic [lin_fault_pkg::TIMER_WIDTH-1:0] next_count;
    logic limitReached;

    // Limit cast once to the counter width
    localparam logic [lin_fault_pkg::TIMER_WIDTH-1:0] LIMIT_W =
        lin_fault_pkg::TIMER_WIDTH'(LIMIT);

    assign limitReached = (count >= LIMIT_W);

    always_comb
    begin
        next_count = '0;
        if (run && !limitReached)
        begin
            next_count = count + 1'b1;
        end
        else if (run)
        begin
            next_count = count;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            count <= '0;
        end
        else
        begin
            count <= next_count;
        end
    end

    assign expired = run && limitReached;

endmodule : lin_level_timer

// ### rtl/lin_fault_and_wake_monitor.sv
// LIN transceiver fault supervision and bus wake-up detection.
// Assumes all pins and analog comparator flags are synchronous to clk;
// bus level 1 is recessive, 0 dominant.
//
// Behaviour
// - Supply undervoltage holds the bus recessive.
// - Transmit input low past timeout turns driver off; receiver keeps working.
// - Transmit timeout clears mode MSB and sets transmit-stuck flag.
// - Driver returns only after mode rewritten normal and transmit seen high.
// - Transmit timeout supervision runs only in normal or listen mode.
// - Receive output high seven dominant cycles disables driver and receiver.
// - Receive-stuck fault clears mode MSB and sets receive-stuck flag.
// - Receive-stuck recovery needs mode normal then a bus falling edge.
// - Receive-stuck supervision runs only in normal or listen mode.
// - Bus dominant past short time flags error; transceiver keeps running.
// - Bus short supervision runs only in normal or listen mode.
// - Current limit holds bus recessive; prior mode resumes afterwards.
// - Overtemperature turns driver off; receiver keeps working.
// - Overtemperature clears mode MSB and sets overtemperature flag.
// - Driver stays off until temperature below threshold minus hysteresis.
// - Four error flags raise interrupt unless inhibit bit set.
// - Low-power off with wake enabled wakes on long dominant pulse.
// - Wake needs fall, dominant past wake time, then rise; qualified at rise.
// - Mode 11 drives bus from transmit input and reports bus level.
// - Mode 01 only reports bus level; driver stays off.
// - Summary bit is OR of four flags; flags stick until reset or read.
`timescale 1ns/1ps

module lin_fault_and_wake_monitor #(
    parameter int TX_DOMINANT_CYCLES = lin_fault_pkg::TX_DOMINANT_CYCLES,
    parameter int BUS_SHORT_CYCLES = lin_fault_pkg::BUS_SHORT_CYCLES,
    parameter int WAKE_PULSE_CYCLES = lin_fault_pkg::WAKE_PULSE_CYCLES
) (
    // Clock and power-on reset
    input wire logic clk,
    input wire logic rst,
    // Mode field control
    input wire logic modeWrite,
    input wire logic [1:0] modeWriteValue,
    output logic [1:0] modeField,
    // Controller pins
    input wire logic busTxInput,
    output logic busRxOutput,
    input wire logic busRxOutputSense,
    // Bus pin
    input wire logic busLevel,
    output logic busDrive,
    // Analog status
    input wire logic supplyUndervoltage,
    input wire logic driverCurrentLimit,
    input wire logic overTempHigh,
    input wire logic overTempBelowHyst,
    // Low-power state
    input wire logic lowPowerOffState,
    input wire logic wakeEnable,
    output logic wakeEvent,
    // Diagnostic flags
    input wire logic diagRead,
    output logic txStuckDominantFlag,
    output logic rxStuckRecessiveFlag,
    output logic busDominantShortFlag,
    output logic driverOvertempFlag,
    output logic linSummary,
    // Interrupt
    input wire logic busErrorIrqInhibit,
    output logic busErrorIrq
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    typedef enum logic [1:0] {
        WAKE_IDLE,
        WAKE_DOMINANT,
        WAKE_LOCKED
    } wake_state_t;

    wake_state_t wakeState;
    wake_state_t next_wakeState;

    logic [1:0] next_modeField;
    logic txFault;
    logic next_txFault;
    logic rxFault;
    logic next_rxFault;
    logic otFault;
    logic next_otFault;
    logic txRearm;
    logic next_txRearm;
    logic rxRearm;
    logic next_rxRearm;
    logic otRearm;
    logic next_otRearm;
    logic [lin_fault_pkg::RX_STUCK_WIDTH-1:0] rxStuckCount;
    logic [lin_fault_pkg::RX_STUCK_WIDTH-1:0] next_rxStuckCount;
    logic busPrev;
    logic next_busDrive;
    logic next_busRxOutput;
    logic next_wakeEvent;
    logic next_txFlag;
    logic next_rxFlag;
    logic next_domFlag;
    logic next_otFlag;

    logic supervise;
    logic txTimeout;
    logic busShort;
    logic wakeLong;
    logic wakeArmed;
    logic busFall;
    logic busRise;
    logic txQual;
    logic rxQual;
    logic otQual;
    logic modeNormalWrite;
    logic driverAllowed;
    logic receiverOn;

    // ----------------------------------------
    // Supervision windows and timers
    // ----------------------------------------
    assign supervise = (modeField == lin_fault_pkg::MODE_NORMAL)
        || (modeField == lin_fault_pkg::MODE_LISTEN);

    assign busFall = busPrev && !busLevel;
    assign busRise = !busPrev && busLevel;
    assign wakeArmed = lowPowerOffState && wakeEnable;

    lin_level_timer #(
        .LIMIT(TX_DOMINANT_CYCLES)
    ) txTimer (
        .clk(clk),
        .rst(rst),
        .run(supervise && !busTxInput && !txFault),
        .expired(txTimeout)
    );

    lin_level_timer #(
        .LIMIT(BUS_SHORT_CYCLES)
    ) shortTimer (
        .clk(clk),
        .rst(rst),
        .run(supervise && !busLevel),
        .expired(busShort)
    );

    // Runs on into the rise cycle, so the pulse length is known there
    lin_level_timer #(
        .LIMIT(WAKE_PULSE_CYCLES)
    ) wakeTimer (
        .clk(clk),
        .rst(rst),
        .run(wakeState == WAKE_DOMINANT),
        .expired(wakeLong)
    );

    // ----------------------------------------
    // Fault qualification
    // ----------------------------------------
    assign txQual = txTimeout;
    // Receive pin high while our driver pulls the bus dominant
    assign rxQual = supervise && !rxFault && busDrive && busRxOutputSense
        && (rxStuckCount == lin_fault_pkg::RX_STUCK_COUNT - 1'b1);
    assign otQual = overTempHigh && !otFault;
    assign modeNormalWrite = modeWrite
        && (modeWriteValue == lin_fault_pkg::MODE_NORMAL);

    // ----------------------------------------
    // Mode, fault and recovery state
    // ----------------------------------------
    always_comb
    begin
        next_modeField = modeField;
        next_txFault = txFault;
        next_rxFault = rxFault;
        next_otFault = otFault;
        next_txRearm = txRearm;
        next_rxRearm = rxRearm;
        next_otRearm = otRearm;
        next_rxStuckCount = lin_fault_pkg::RX_STUCK_RESET;

        if (modeWrite)
        begin
            next_modeField = modeWriteValue;
        end
        // A fault in the same cycle clears the MSB of the write
        if (txQual || rxQual || otQual)
        begin
            next_modeField[lin_fault_pkg::MODE_MSB] = 1'b0;
        end

        // Seven consecutive stuck cycles
        if (supervise && !rxFault && busDrive && busRxOutputSense)
        begin
            next_rxStuckCount = rxStuckCount + 1'b1;
        end

        // Transmit timeout latch and release
        if (txQual)
        begin
            next_txFault = 1'b1;
            next_txRearm = 1'b0;
        end
        else if (txFault && modeNormalWrite)
        begin
            next_txRearm = 1'b1;
        end
        else if (txFault && txRearm && busTxInput)
        begin
            next_txFault = 1'b0;
            next_txRearm = 1'b0;
        end

        // Receive stuck latch and release on a fresh dominant edge
        if (rxQual)
        begin
            next_rxFault = 1'b1;
            next_rxRearm = 1'b0;
        end
        else if (rxFault && modeNormalWrite)
        begin
            next_rxRearm = 1'b1;
        end
        else if (rxFault && rxRearm && busFall)
        begin
            next_rxFault = 1'b0;
            next_rxRearm = 1'b0;
        end

        // Overtemperature: hysteresis beats any software request
        if (otQual)
        begin
            next_otFault = 1'b1;
            next_otRearm = 1'b0;
        end
        else if (otFault && modeNormalWrite)
        begin
            next_otRearm = 1'b1;
        end
        else if (otFault && otRearm && busTxInput && overTempBelowHyst)
        begin
            next_otFault = 1'b0;
            next_otRearm = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            modeField <= lin_fault_pkg::MODE_RESET;
            txFault <= 1'b0;
            rxFault <= 1'b0;
            otFault <= 1'b0;
            txRearm <= 1'b0;
            rxRearm <= 1'b0;
            otRearm <= 1'b0;
            rxStuckCount <= lin_fault_pkg::RX_STUCK_RESET;
        end
        else
        begin
            modeField <= next_modeField;
            txFault <= next_txFault;
            rxFault <= next_rxFault;
            otFault <= next_otFault;
            txRearm <= next_txRearm;
            rxRearm <= next_rxRearm;
            otRearm <= next_otRearm;
            rxStuckCount <= next_rxStuckCount;
        end
    end

    // ----------------------------------------
    // Driver and receiver
    // ----------------------------------------
    // Current limit and undervoltage only mask the drive; no state is lost
    assign driverAllowed = (modeField == lin_fault_pkg::MODE_NORMAL)
        && !txFault && !rxFault && !otFault
        && !supplyUndervoltage
        && !driverCurrentLimit
        && !lowPowerOffState;
    assign receiverOn = supervise && !rxFault;

    always_comb
    begin
        next_busDrive = driverAllowed && !busTxInput && !txQual
            && !rxQual && !otQual;
        next_busRxOutput = 1'b1;
        if (lowPowerOffState)
        begin
            next_busRxOutput = 1'b0;
        end
        else if (receiverOn && !rxQual)
        begin
            next_busRxOutput = busLevel;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            busDrive <= 1'b0;
            busRxOutput <= 1'b1;
            busPrev <= 1'b1;
        end
        else
        begin
            busDrive <= next_busDrive;
            busRxOutput <= next_busRxOutput;
            busPrev <= busLevel;
        end
    end

    // ----------------------------------------
    // Sticky diagnostic flags
    // ----------------------------------------
    // Set wins over a clear-on-read in the same cycle
    always_comb
    begin
        next_txFlag = (txStuckDominantFlag && !diagRead) || txQual;
        next_rxFlag = (rxStuckRecessiveFlag && !diagRead) || rxQual;
        next_domFlag = (busDominantShortFlag && !diagRead) || busShort;
        next_otFlag = (driverOvertempFlag && !diagRead) || otQual;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            txStuckDominantFlag <= 1'b0;
            rxStuckRecessiveFlag <= 1'b0;
            busDominantShortFlag <= 1'b0;
            driverOvertempFlag <= 1'b0;
        end
        else
        begin
            txStuckDominantFlag <= next_txFlag;
            rxStuckRecessiveFlag <= next_rxFlag;
            busDominantShortFlag <= next_domFlag;
            driverOvertempFlag <= next_otFlag;
        end
    end

    assign linSummary = txStuckDominantFlag || rxStuckRecessiveFlag
        || busDominantShortFlag || driverOvertempFlag;
    assign busErrorIrq = linSummary && !busErrorIrqInhibit;

    // ----------------------------------------
    // Wake pulse detection
    // ----------------------------------------
    // A bus already dominant at entry waits for recessive first, so a
    // stuck bus cannot wake the device.
    always_comb
    begin
        next_wakeState = wakeState;
        next_wakeEvent = 1'b0;
        case (wakeState)
            WAKE_IDLE:
            begin
                if (wakeArmed && busFall)
                begin
                    next_wakeState = WAKE_DOMINANT;
                end
            end
            WAKE_DOMINANT:
            begin
                if (!wakeArmed)
                begin
                    next_wakeState = WAKE_IDLE;
                end
                else if (busRise)
                begin
                    next_wakeEvent = wakeLong;
                    next_wakeState = WAKE_IDLE;
                end
            end
            WAKE_LOCKED:
            begin
                next_wakeState = WAKE_IDLE;
            end
            default:
            begin
                next_wakeState = WAKE_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wakeState <= WAKE_IDLE;
            wakeEvent <= 1'b0;
        end
        else
        begin
            wakeState <= next_wakeState;
            wakeEvent <= next_wakeEvent;
        end
    end

endmodule : lin_fault_and_wake_monitor

// ### tb/lin_fault_assertions.sv
// Concurrent checks on the ports of the LIN fault and wake monitor.
// Assumes one clock domain and binding into every monitor instance.
`timescale 1ns/1ps
module lin_fault_assertions #(
    parameter int TX_DOMINANT_CYCLES = 20,
    parameter int BUS_SHORT_CYCLES = 30,
    parameter int WAKE_PULSE_CYCLES = 10
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pins and mode
    input wire logic [1:0] modeField,
    input wire logic busTxInput,
    input wire logic busRxOutputSense,
    input wire logic busLevel,
    input wire logic busDrive,
    input wire logic supplyUndervoltage,
    input wire logic driverCurrentLimit,
    input wire logic overTempHigh,
    input wire logic lowPowerOffState,
    input wire logic wakeEnable,
    input wire logic wakeEvent,
    // Flags
    input wire logic txStuckDominantFlag,
    input wire logic rxStuckRecessiveFlag,
    input wire logic busDominantShortFlag,
    input wire logic driverOvertempFlag,
    input wire logic linSummary,
    input wire logic busErrorIrqInhibit,
    input wire logic busErrorIrq
);
    // ----------------------------------------
    // Run-length counters
    // ----------------------------------------
    // Never saturate; runs stay far below the int range
    int txLowCount;
    int shortCount;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            txLowCount <= 0;
            shortCount <= 0;
        end
        else
        begin
            txLowCount <= (!busTxInput && modeField[0]) ? txLowCount + 1 : 0;
            shortCount <= (!busLevel && modeField[0]) ? shortCount + 1 : 0;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    a_uv_recessive: assert property (supplyUndervoltage |=> !busDrive)
        else $error("driver on during undervoltage");
    a_ilim_recessive: assert property (driverCurrentLimit |=> !busDrive)
        else $error("driver on during current limit");
    a_listen_no_drive: assert property (
        modeField != lin_fault_pkg::MODE_NORMAL |=> !busDrive)
        else $error("driver on outside normal mode");
    a_drive_cause: assert property (
        $rose(busDrive) |->
        $past(modeField) == lin_fault_pkg::MODE_NORMAL && !$past(busTxInput))
        else $error("driver on without a low transmit input");
    a_ot_shutdown: assert property (overTempHigh |=> !busDrive)
        else $error("driver on while overheated");
    a_fault_msb: assert property (
        $rose(txStuckDominantFlag) || $rose(rxStuckRecessiveFlag)
        || $rose(driverOvertempFlag) |-> !modeField[1])
        else $error("mode top bit not cleared by fault");
    a_rx_stuck_trip: assert property (
        (busDrive && busRxOutputSense && modeField[0])[*7]
        |=> rxStuckRecessiveFlag && !busDrive)
        else $error("stuck receive not caught after seven cycles");
    a_tx_timeout: assert property (
        txLowCount == TX_DOMINANT_CYCLES + 1
        |-> ##[0:2] (txStuckDominantFlag && !busDrive))
        else $error("transmit timeout missed");
    a_short_flag: assert property (
        shortCount == BUS_SHORT_CYCLES + 1
        |-> ##[0:2] busDominantShortFlag)
        else $error("bus short missed");
    a_summary_or: assert property (
        linSummary == (txStuckDominantFlag || rxStuckRecessiveFlag
        || busDominantShortFlag || driverOvertempFlag))
        else $error("summary bit differs from flags");
    a_irq_gate: assert property (busErrorIrq == (linSummary && !busErrorIrqInhibit))
        else $error("interrupt gating wrong");
    a_wake_cause: assert property (
        wakeEvent |->
        $past(lowPowerOffState) && $past(wakeEnable) && $past(busLevel))
        else $error("wake outside low power");
    c_rx_stuck: cover property ($rose(rxStuckRecessiveFlag));
    c_wake: cover property (wakeEvent);
    c_short: cover property ($rose(busDominantShortFlag));
endmodule : lin_fault_assertions
bind lin_fault_and_wake_monitor lin_fault_assertions #(
    .TX_DOMINANT_CYCLES(TX_DOMINANT_CYCLES),
    .BUS_SHORT_CYCLES(BUS_SHORT_CYCLES),
    .WAKE_PULSE_CYCLES(WAKE_PULSE_CYCLES)
) lin_fault_assertions_i (.*);

// ### tb/lin_host_model.sv
// Host LIN controller pin model plus the bus wire seen by the monitor.
// Assumes the bench changes its commands at falling clock edges.
`timescale 1ns/1ps
module lin_host_model (
    // Bench commands
    input wire logic txCmd,
    input wire logic stuckRx,
    input wire logic extDominant,
    // Monitor pins
    input wire logic busDrive,
    input wire logic busRxOutput,
    output logic busTxInput,
    output logic busRxOutputSense,
    output logic busLevel
);
    // Low requests dominant; high leaves the bus to its pull-up
    assign busTxInput = txCmd;
    // Pull-up wins unless the driver or another node pulls low
    assign busLevel = !(busDrive || extDominant);
    // Receive pin shorted high hides what the monitor drives
    assign busRxOutputSense = stuckRx ? 1'h1 : busRxOutput;
endmodule : lin_host_model

// ### tb/lin_fault_and_wake_monitor_bench.sv
// Self-checking bench for the LIN fault and wake monitor.
// Assumes short sim counts; inputs change on falling clock edges.
`timescale 1ns/1ps
module lin_fault_and_wake_monitor_bench;
    typedef struct packed {logic [1:0] mode; logic tx; logic uv; logic ilim; logic drive;} row_t;
    localparam int TX_CYC = 20;
    localparam int SHORT_CYC = 30;
    localparam int WAKE_CYC = 10;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic modeWrite = 1'h0;
    logic [1:0] modeWriteValue = 2'h0;
    logic txCmd = 1'h1, stuckRx = 1'h0, extDominant = 1'h0, diagRead = 1'h0;
    logic supplyUndervoltage = 1'h0, driverCurrentLimit = 1'h0, overTempHigh = 1'h0;
    logic overTempBelowHyst = 1'h1, lowPowerOffState = 1'h0, wakeEnable = 1'h0;
    logic busErrorIrqInhibit = 1'h0, wakeSeen = 1'h0;
    logic [1:0] modeField;
    logic busTxInput, busRxOutput, busRxOutputSense, busLevel, busDrive, wakeEvent;
    logic txStuckDominantFlag, rxStuckRecessiveFlag, busDominantShortFlag;
    logic driverOvertempFlag, linSummary, busErrorIrq;
    logic [3:0] flags;
    int failures = 0;
    int n_tests = 0;
    row_t rows [8] = '{'{2'h3, 1'h0, 1'h0, 1'h0, 1'h1}, '{2'h3, 1'h1, 1'h0, 1'h0, 1'h0},
        '{2'h3, 1'h0, 1'h1, 1'h0, 1'h0}, '{2'h3, 1'h0, 1'h0, 1'h1, 1'h0},
        '{2'h3, 1'h0, 1'h0, 1'h0, 1'h1}, '{2'h1, 1'h0, 1'h0, 1'h0, 1'h0},
        '{2'h0, 1'h0, 1'h0, 1'h0, 1'h0}, '{2'h2, 1'h0, 1'h0, 1'h0, 1'h0}};
    assign flags = {txStuckDominantFlag, rxStuckRecessiveFlag, busDominantShortFlag,
        driverOvertempFlag};
    lin_fault_and_wake_monitor #(
        .TX_DOMINANT_CYCLES(TX_CYC),
        .BUS_SHORT_CYCLES(SHORT_CYC),
        .WAKE_PULSE_CYCLES(WAKE_CYC)
    ) lin_fault_and_wake_monitor_i (.*);
    lin_host_model lin_host_model_i (.*);
    always #50 clk = ~clk;
    always @(posedge clk) if (wakeEvent === 1'h1) wakeSeen <= 1'h1;
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic set_mode(input logic [1:0] m);
        modeWriteValue = m;
        modeWrite = 1'h1;
        cyc(1);
        modeWrite = 1'h0;
        cyc(1);
    endtask : set_mode
    task automatic read_clear();
        diagRead = 1'h1;
        cyc(1);
        diagRead = 1'h0;
        cyc(1);
    endtask : read_clear
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test
    initial
    begin
        #(100 * 5000);
        failures++;
        finish_test();
    end
    initial
    begin
        cyc(11);
        check({busDrive, busRxOutput, modeField}, 4'h4);
        check(flags, 4'h0);
        cyc(1);
        rst = 1'h0;
        $display("Test reset done");
        foreach (rows[i])
        begin
            txCmd = 1'h1;
            set_mode(rows[i].mode);
            txCmd = rows[i].tx;
            supplyUndervoltage = rows[i].uv;
            driverCurrentLimit = rows[i].ilim;
            cyc(2);
            check(busDrive, rows[i].drive);
            check(busRxOutput, !rows[i].drive);
            supplyUndervoltage = 1'h0;
            driverCurrentLimit = 1'h0;
        end
        $display("Test table done");
        txCmd = 1'h1;
        set_mode(2'h3);
        txCmd = 1'h0;
        cyc(TX_CYC - 5);
        check(txStuckDominantFlag, 1'h0);
        for (int i = 0; i < TX_CYC && txStuckDominantFlag !== 1'h1; i++) cyc(1);
        cyc(1);
        check({txStuckDominantFlag, modeField, busDrive}, 4'hA);
        check({linSummary, busErrorIrq}, 2'h3);
        busErrorIrqInhibit = 1'h1;
        cyc(1);
        check(busErrorIrq, 1'h0);
        busErrorIrqInhibit = 1'h0;
        extDominant = 1'h1;
        cyc(2);
        check(busRxOutput, 1'h0);
        extDominant = 1'h0;
        set_mode(2'h3);
        cyc(1);
        check(busDrive, 1'h0);
        txCmd = 1'h1;
        cyc(2);
        txCmd = 1'h0;
        cyc(2);
        check(busDrive, 1'h1);
        txCmd = 1'h1;
        read_clear();
        check(flags, 4'h0);
        set_mode(2'h0);
        txCmd = 1'h0;
        cyc(2 * TX_CYC);
        check(txStuckDominantFlag, 1'h0);
        txCmd = 1'h1;
        $display("Test transmit timeout done");
        set_mode(2'h3);
        txCmd = 1'h0;
        stuckRx = 1'h1;
        for (int i = 0; i < 15 && rxStuckRecessiveFlag !== 1'h1; i++) cyc(1);
        cyc(1);
        check({rxStuckRecessiveFlag, modeField, busDrive}, 4'hA);
        check(busRxOutput, 1'h1);
        txCmd = 1'h1;
        stuckRx = 1'h0;
        set_mode(2'h3);
        txCmd = 1'h0;
        cyc(2);
        check(busDrive, 1'h0);
        extDominant = 1'h1;
        cyc(1);
        extDominant = 1'h0;
        cyc(2);
        check(busDrive, 1'h1);
        txCmd = 1'h1;
        read_clear();
        $display("Test receive stuck done");
        set_mode(2'h3);
        overTempHigh = 1'h1;
        overTempBelowHyst = 1'h0;
        cyc(1);
        overTempHigh = 1'h0;
        cyc(1);
        check({driverOvertempFlag, modeField, busDrive}, 4'hA);
        set_mode(2'h3);
        txCmd = 1'h0;
        cyc(2);
        check(busDrive, 1'h0);
        txCmd = 1'h1;
        overTempBelowHyst = 1'h1;
        cyc(2);
        txCmd = 1'h0;
        cyc(2);
        check(busDrive, 1'h1);
        txCmd = 1'h1;
        read_clear();
        $display("Test overtemperature done");
        extDominant = 1'h1;
        cyc(SHORT_CYC - 5);
        check(busDominantShortFlag, 1'h0);
        cyc(12);
        check({busDominantShortFlag, 1'h0, modeField}, 4'hB);
        rst = 1'h1;
        cyc(1);
        check(flags, 4'h0);
        check({busDrive, busRxOutput, modeField}, 4'h4);
        rst = 1'h0;
        $display("Test mid-run reset done");
        extDominant = 1'h0;
        cyc(2);
        read_clear();
        set_mode(2'h0);
        extDominant = 1'h1;
        cyc(2 * SHORT_CYC);
        check(busDominantShortFlag, 1'h0);
        extDominant = 1'h0;
        $display("Test bus short done");
        lowPowerOffState = 1'h1;
        for (int k = 0; k < 3; k++)
        begin
            wakeEnable = (k > 0);
            wakeSeen = 1'h0;
            extDominant = 1'h1;
            cyc(k == 1 ? WAKE_CYC / 2 : WAKE_CYC + 5);
            check(wakeSeen, 1'h0);
            extDominant = 1'h0;
            cyc(4);
            check(wakeSeen, k == 2);
        end
        check(busRxOutput, 1'h0);
        lowPowerOffState = 1'h0;
        $display("Test wake done");
        finish_test();
    end
endmodule : lin_fault_and_wake_monitor_bench
